// ===== src/pef_pkg.sv
package pef_pkg;

    // Register offsets on the local port
    localparam logic [7:0] PEF_ADDR_PORT  = 8'h90;
    localparam logic [7:0] PEF_ADDR_FLAGS = 8'h91;
    localparam logic [7:0] PEF_ADDR_IEN   = 8'hA0;
    localparam logic [7:0] PEF_ADDR_ICLR  = 8'hA1;
    localparam logic [7:0] PEF_ADDR_IRQST = 8'hA2;

    // Reset values
    localparam logic [7:0] PEF_PORT_RESET  = 8'hFF;
    localparam logic [7:0] PEF_FLAGS_RESET = 8'h00;
    localparam logic [3:0] PEF_IEN_RESET   = 4'h0;

    // Field positions in the flag register
    localparam int PEF_FLAG_LSB = 4;
    localparam int PEF_FLAG_MSB = 7;

    // Edge polarity per interrupt input, bit 0 = input 2: 1 rising, 0 falling
    localparam logic [3:0] PEF_EDGE_RISING = 4'h5;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } pef_bus_type;

    typedef struct packed {
        logic [7:0] port_latch;
        logic [3:0] pin_prev;
        logic [3:0] edge_flags;
        logic [3:0] irq_status;
        logic [3:0] irq_enable;
        logic [7:0] rdata;
    } pef_state_type;

endpackage

// ===== src/pef_port_one_edge_irq_flags.sv
`timescale 1ns/100ps
// Overview of operation
// - Bit 7 flag sets on a falling edge of external input five.
// - Bit 6 flag sets on a rising edge of external input four.
// - Bit 5 flag sets on a falling edge of external input three.
// - Bit 4 flag sets on a rising edge of external input two.
// - Flag register holds flags in bits 7..4; bits 3..0 read zero.
// - Port bits 4..7 are interrupt inputs two to five and general I/O.
// - Reset loads the port latch with all ones, pins released high.
module pef_port_one_edge_irq_flags
(
    input  wire logic                clk_sys,
    input  wire logic                rst,
    input  wire pef_pkg::pef_bus_type bus,
    output logic [7:0]               rdata,
    input  wire logic [7:0]          port_pin_in,
    output logic [7:0]               port_pin_out,
    output logic [7:0]               port_pin_oe_n,
    output logic [3:0]               edge_flag_out,
    output logic                     irq
);
    import pef_pkg::*;

    pef_state_type state;
    pef_state_type next_state;
    logic [3:0]    irq_pins;
    logic [3:0]    rise;
    logic [3:0]    fall;
    logic [3:0]    edge_hit;

    // Interrupt inputs ext_irq_in2..5 are port pins 4..7
    assign irq_pins = port_pin_in[PEF_FLAG_MSB:PEF_FLAG_LSB];
    assign rise     = irq_pins & ~state.pin_prev;
    assign fall     = ~irq_pins & state.pin_prev;
    // Polarity per input: 2 and 4 rising, 3 and 5 falling
    assign edge_hit = (rise & PEF_EDGE_RISING) | (fall & ~PEF_EDGE_RISING);

    // Next-state logic for registers, flags and read data
    always_comb
    begin
        next_state = state;
        next_state.pin_prev = irq_pins;
        next_state.rdata = 8'h00;
        if (bus.wr)
        begin
            unique case (bus.addr)
                PEF_ADDR_PORT:
                begin
                    next_state.port_latch = bus.wdata;
                end
                PEF_ADDR_FLAGS:
                begin
                    // Writing zero clears, writing one keeps
                    next_state.edge_flags = state.edge_flags
                        & bus.wdata[PEF_FLAG_MSB:PEF_FLAG_LSB];
                end
                PEF_ADDR_IEN:
                begin
                    next_state.irq_enable = bus.wdata[3:0];
                end
                PEF_ADDR_ICLR:
                begin
                    next_state.irq_status = state.irq_status & ~bus.wdata[3:0];
                end
                default:
                begin
                end
            endcase
        end
        // Edge sets win over same-cycle clears
        next_state.edge_flags = next_state.edge_flags | edge_hit;
        next_state.irq_status = next_state.irq_status | edge_hit;
        if (bus.rd)
        begin
            // Read data is registered and stands one cycle only
            unique case (bus.addr)
                PEF_ADDR_PORT:
                begin
                    next_state.rdata = port_pin_in;
                end
                PEF_ADDR_FLAGS:
                begin
                    next_state.rdata = {state.edge_flags, 4'h0};
                end
                PEF_ADDR_IEN:
                begin
                    next_state.rdata = {4'h0, state.irq_enable};
                end
                PEF_ADDR_IRQST:
                begin
                    next_state.rdata = {4'h0, state.irq_status};
                end
                default:
                begin
                    next_state.rdata = 8'h00;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            state.port_latch <= PEF_PORT_RESET;
            state.pin_prev   <= 4'hF;
            state.edge_flags <= PEF_FLAGS_RESET[3:0];
            state.irq_status <= 4'h0;
            state.irq_enable <= PEF_IEN_RESET;
            state.rdata      <= 8'h00;
        end
        else
        begin
            state <= next_state;
        end
    end

    // Quasi-bidirectional port: drive low only, high is released
    assign port_pin_out  = state.port_latch;
    assign port_pin_oe_n = state.port_latch;
    assign rdata         = state.rdata;
    assign edge_flag_out = state.edge_flags;
    assign irq           = |(state.irq_status & state.irq_enable);

    // Falling edge on input five sets bit 7 next cycle
    fall_five_a : assert property (@(posedge clk_sys) disable iff (rst)
        (state.pin_prev[3] && !irq_pins[3]) |=> state.edge_flags[3])
        else $error("falling edge on input five not flagged");
    // Rising edge on input four sets bit 6
    rise_four_a : assert property (@(posedge clk_sys) disable iff (rst)
        (!state.pin_prev[2] && irq_pins[2]) |=> state.edge_flags[2])
        else $error("rising edge on input four not flagged");
    // Falling edge on input three sets bit 5
    fall_three_a : assert property (@(posedge clk_sys) disable iff (rst)
        (state.pin_prev[1] && !irq_pins[1]) |=> state.edge_flags[1])
        else $error("falling edge on input three not flagged");
    // Rising edge on input two sets bit 4
    rise_two_a : assert property (@(posedge clk_sys) disable iff (rst)
        (!state.pin_prev[0] && irq_pins[0]) |=> state.edge_flags[0])
        else $error("rising edge on input two not flagged");
    // Flag read shows flags high, zero low
    flag_read_a : assert property (@(posedge clk_sys) disable iff (rst)
        (bus.rd && bus.addr == PEF_ADDR_FLAGS) |=>
        rdata == {$past(state.edge_flags), 4'h0})
        else $error("flag register read layout wrong");
    // Port latch is all ones after reset
    port_reset_a : assert property (@(posedge clk_sys)
        $fell(rst) |-> port_pin_out == 8'hFF)
        else $error("port latch not all ones after reset");
    // Flag stays set without a clearing write
    flag_hold_a : assert property (@(posedge clk_sys) disable iff (rst)
        (state.edge_flags[3] && !(bus.wr && bus.addr == PEF_ADDR_FLAGS))
        |=> state.edge_flags[3])
        else $error("edge flag lost without a write");
    // Zero write with no edge clears the flag
    flag_clear_a : assert property (@(posedge clk_sys) disable iff (rst)
        (bus.wr && bus.addr == PEF_ADDR_FLAGS && !bus.wdata[4] && !edge_hit[0])
        |=> !state.edge_flags[0])
        else $error("edge flag not cleared by zero write");
    // Enabled edge raises the interrupt next cycle
    irq_level_a : assert property (@(posedge clk_sys) disable iff (rst)
        ((edge_hit & state.irq_enable) != 4'h0) |=> irq)
        else $error("interrupt output not raised by enabled edge");

    // Falling edge on input five sets its status bit
    stat_five_a : assert property (@(posedge clk_sys) disable iff (rst)
        edge_hit[3] |=> state.irq_status[3])
        else $error("status five not set");

    // Rising edge on input four sets its status bit
    stat_four_a : assert property (@(posedge clk_sys) disable iff (rst)
        edge_hit[2] |=> state.irq_status[2])
        else $error("status four not set");

    // Falling edge on input three sets its status bit
    stat_three_a : assert property (@(posedge clk_sys) disable iff (rst)
        edge_hit[1] |=> state.irq_status[1])
        else $error("status three not set");

    // Rising edge on input two sets its status bit
    stat_two_a : assert property (@(posedge clk_sys) disable iff (rst)
        edge_hit[0] |=> state.irq_status[0])
        else $error("status two not set");

    // Rising edge on input five leaves a clear flag clear
    no_rise_five_a : assert property (@(posedge clk_sys) disable iff (rst)
        (!state.pin_prev[3] && irq_pins[3] && !state.edge_flags[3]) |=> !state.edge_flags[3])
        else $error("input five flagged on a rising edge");

    // Falling edge on input four leaves a clear flag clear
    no_fall_four_a : assert property (@(posedge clk_sys) disable iff (rst)
        (state.pin_prev[2] && !irq_pins[2] && !state.edge_flags[2]) |=> !state.edge_flags[2])
        else $error("input four flagged on a falling edge");

    // Rising edge on input three leaves a clear flag clear
    no_rise_three_a : assert property (@(posedge clk_sys) disable iff (rst)
        (!state.pin_prev[1] && irq_pins[1] && !state.edge_flags[1]) |=> !state.edge_flags[1])
        else $error("input three flagged on a rising edge");

    // Falling edge on input two leaves a clear flag clear
    no_fall_two_a : assert property (@(posedge clk_sys) disable iff (rst)
        (state.pin_prev[0] && !irq_pins[0] && !state.edge_flags[0]) |=> !state.edge_flags[0])
        else $error("input two flagged on a falling edge");

    // Flag six stays set without a clearing write
    hold_six_a : assert property (@(posedge clk_sys) disable iff (rst)
        (state.edge_flags[2] && !(bus.wr && bus.addr == PEF_ADDR_FLAGS))
        |=> state.edge_flags[2])
        else $error("flag six lost without a write");

    // Flag five stays set without a clearing write
    hold_five_a : assert property (@(posedge clk_sys) disable iff (rst)
        (state.edge_flags[1] && !(bus.wr && bus.addr == PEF_ADDR_FLAGS))
        |=> state.edge_flags[1])
        else $error("flag five lost without a write");

    // Flag four stays set without a clearing write
    hold_four_a : assert property (@(posedge clk_sys) disable iff (rst)
        (state.edge_flags[0] && !(bus.wr && bus.addr == PEF_ADDR_FLAGS))
        |=> state.edge_flags[0])
        else $error("flag four lost without a write");

    // Zero write clears flag seven
    clear_seven_a : assert property (@(posedge clk_sys) disable iff (rst)
        (bus.wr && bus.addr == PEF_ADDR_FLAGS && !bus.wdata[7] && !edge_hit[3])
        |=> !state.edge_flags[3])
        else $error("flag seven not cleared by zero write");

    // Zero write clears flag six
    clear_six_a : assert property (@(posedge clk_sys) disable iff (rst)
        (bus.wr && bus.addr == PEF_ADDR_FLAGS && !bus.wdata[6] && !edge_hit[2])
        |=> !state.edge_flags[2])
        else $error("flag six not cleared by zero write");

    // Zero write clears flag five
    clear_five_a : assert property (@(posedge clk_sys) disable iff (rst)
        (bus.wr && bus.addr == PEF_ADDR_FLAGS && !bus.wdata[5] && !edge_hit[1])
        |=> !state.edge_flags[1])
        else $error("flag five not cleared by zero write");

    // One written to a set flag keeps it
    keep_one_a : assert property (@(posedge clk_sys) disable iff (rst)
        (bus.wr && bus.addr == PEF_ADDR_FLAGS && bus.wdata[7] && state.edge_flags[3])
        |=> state.edge_flags[3])
        else $error("flag seven lost on a write of one");

    // Edge in the clearing cycle wins over the clear
    set_wins_a : assert property (@(posedge clk_sys) disable iff (rst)
        (bus.wr && bus.addr == PEF_ADDR_FLAGS && edge_hit[0]) |=> state.edge_flags[0])
        else $error("edge lost against a clearing write");

    // Port write lands in the latch
    port_write_a : assert property (@(posedge clk_sys) disable iff (rst)
        (bus.wr && bus.addr == PEF_ADDR_PORT) |=> port_pin_out == $past(bus.wdata))
        else $error("port latch write lost");

    // Port read returns the pin levels
    port_read_a : assert property (@(posedge clk_sys) disable iff (rst)
        (bus.rd && bus.addr == PEF_ADDR_PORT) |=> rdata == $past(port_pin_in))
        else $error("port read data wrong");

    // Low nibble of the flag register reads zero
    low_nibble_a : assert property (@(posedge clk_sys) disable iff (rst)
        (bus.rd && bus.addr == PEF_ADDR_FLAGS) |=> rdata[3:0] == 4'h0)
        else $error("unused flag bits not zero");

    // Read data returns to zero without a read
    rdata_idle_a : assert property (@(posedge clk_sys) disable iff (rst)
        !bus.rd |=> rdata == 8'h00)
        else $error("read data not zero when idle");

    // Unmapped and write-only addresses read zero
    unmapped_a : assert property (@(posedge clk_sys) disable iff (rst)
        (bus.rd && bus.addr != PEF_ADDR_PORT && bus.addr != PEF_ADDR_FLAGS
        && bus.addr != PEF_ADDR_IEN && bus.addr != PEF_ADDR_IRQST) |=> rdata == 8'h00)
        else $error("unmapped read not zero");

    // Enable register reads back in the low nibble
    enable_read_a : assert property (@(posedge clk_sys) disable iff (rst)
        (bus.rd && bus.addr == PEF_ADDR_IEN) |=> rdata == {4'h0, $past(state.irq_enable)})
        else $error("enable read data wrong");

    // Status register reads back in the low nibble
    status_read_a : assert property (@(posedge clk_sys) disable iff (rst)
        (bus.rd && bus.addr == PEF_ADDR_IRQST) |=> rdata == {4'h0, $past(state.irq_status)})
        else $error("status read data wrong");

    // Enable write lands in the enable register
    enable_write_a : assert property (@(posedge clk_sys) disable iff (rst)
        (bus.wr && bus.addr == PEF_ADDR_IEN) |=> state.irq_enable == $past(bus.wdata[3:0]))
        else $error("enable write lost");

    // Write of one clears a status bit with no edge
    status_clear_a : assert property (@(posedge clk_sys) disable iff (rst)
        (bus.wr && bus.addr == PEF_ADDR_ICLR && bus.wdata[0] && !edge_hit[0])
        |=> !state.irq_status[0])
        else $error("status bit not cleared");

    // Flags, interrupt and read data are clear after reset
    reset_clear_a : assert property (@(posedge clk_sys)
        $fell(rst) |-> (edge_flag_out == 4'h0 && !irq && rdata == 8'h00))
        else $error("flags or interrupt not clear after reset");

    // No interrupt while nothing is enabled
    irq_masked_a : assert property (@(posedge clk_sys) disable iff (rst)
        (state.irq_enable == 4'h0) |-> !irq)
        else $error("interrupt raised while masked");

endmodule

// ===== verification/pef_pin_model.sv
`timescale 1ns/100ps
// Outside circuit on the port pins, pull-up style
module pef_pin_model
(
    input  wire logic [7:0] ext_level,
    input  wire logic [7:0] port_pin_oe_n,
    output logic [7:0]      port_pin_in
);
    // Pin reads low where either side pulls it low
    assign port_pin_in = ext_level & port_pin_oe_n;
endmodule

// ===== verification/testbench.sv
`timescale 1ns/100ps
module testbench;
    import pef_pkg::*;
    logic        clk_sys, rst, irq;
    pef_bus_type bus;
    logic [7:0]  rdata, pin_in, pin_out, oe_n, ext_level, d;
    logic [3:0]  flags, exp_flags, exp_stat, exp_en, prev_pin, ed;
    int          fails, samples_checked;
    pef_port_one_edge_irq_flags pef_port_one_edge_irq_flags_i (.clk_sys(clk_sys), .rst(rst),
        .bus(bus), .rdata(rdata), .port_pin_in(pin_in), .port_pin_out(pin_out),
        .port_pin_oe_n(oe_n), .edge_flag_out(flags), .irq(irq));
    pef_pin_model pef_pin_model_i (.ext_level(ext_level), .port_pin_oe_n(oe_n),
        .port_pin_in(pin_in));
    // Rising edge on inputs two and four, falling on three and five
    function automatic logic [3:0] edges(input logic [3:0] p, input logic [3:0] c);
        return (PEF_EDGE_RISING & ~p & c) | (~PEF_EDGE_RISING & p & ~c);
    endfunction
    // Reference copy of flags, status and enable
    always @(posedge clk_sys)
    begin
        ed = edges(prev_pin, pin_in[7:4]);
        prev_pin <= rst ? 4'hF : pin_in[7:4];
        exp_flags <= rst ? 4'h0 : (exp_flags & ((bus.wr && bus.addr === PEF_ADDR_FLAGS)
            ? bus.wdata[7:4] : 4'hF)) | ed;
        exp_stat <= rst ? 4'h0 : (exp_stat & ~((bus.wr && bus.addr === PEF_ADDR_ICLR)
            ? bus.wdata[3:0] : 4'h0)) | ed;
        exp_en <= rst ? 4'h0 : (bus.wr && bus.addr === PEF_ADDR_IEN) ? bus.wdata[3:0] : exp_en;
    end
    task automatic check(input logic ok, input string m);
        samples_checked++;
        if (!ok)
        begin
            fails++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        bus.wr <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        bus.rd <= 1'b0;
        @(negedge clk_sys);
        check(rdata === e, "read data");
        @(posedge clk_sys);
    endtask
    task automatic close_out();
        $display("checks %0d fails %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Flags and interrupt compared every cycle
    always @(negedge clk_sys)
        if (rst === 1'b0)
            check(flags === exp_flags && irq === |(exp_stat & exp_en), "flag");
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // Watchdog
    initial
    begin
        #200000;
        fails++;
        close_out();
    end
    initial
    begin
        rst = 1'b1;
        bus = '0;
        ext_level = 8'hFF;
        void'($urandom(1518));
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        @(negedge clk_sys);
        check(pin_out === PEF_PORT_RESET && oe_n === 8'hFF, "port reset");
        @(posedge clk_sys);
        rd(8'h5A, 8'h00);
        $display("reset test done");
        repeat (4)
        begin
            d = $urandom;
            wr(PEF_ADDR_IEN, d);
            wr(PEF_ADDR_PORT, d);
            check(pin_out === d, "latch");
            repeat (150)
            begin
                ext_level <= $urandom;
                d = $urandom;
                if (d[1:0] == 2'h0)
                    wr(d[2] ? PEF_ADDR_FLAGS : PEF_ADDR_ICLR, $urandom);
                else
                    @(posedge clk_sys);
            end
            repeat (2) @(posedge clk_sys);
            rd(PEF_ADDR_PORT, pin_in);
            rd(PEF_ADDR_FLAGS, {exp_flags, 4'h0});
            rd(PEF_ADDR_IRQST, {4'h0, exp_stat});
            rd(PEF_ADDR_IEN, {4'h0, exp_en});
            rd(PEF_ADDR_ICLR, 8'h00);
            wr(PEF_ADDR_PORT, 8'hFF);
            $display("edge test done");
        end
        close_out();
    end
endmodule
